//--- hw/tmr_timer.sv
// What this block does
// - Prescaler used only while bypass bit clear
// - Eight ratios 1:2 to 1:256 by select
// - Bypass set counts every event, ratio 1:1
// - Prescaler count never readable nor writable
// - Count register write clears prescaler
// - Wrap from ff to 00 sets flag
// - Flag sets even with interrupt disabled
// - Flag stays set until software clears
// - Interrupt only when flag and enable set
// - External edges sampled at Q2 and Q4
// - Sleep stops all counting
// - Count held through sleep, resumes after
`include "tmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module tmr_timer #(
    // Sizes; the logic serves only these values
    parameter int COUNT_W = 8,
    parameter int SEL_W = 3,
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side
    input wire logic sleep_active,
    input wire logic ext_count_in,
    // Interrupt
    output logic irq
);

    // ======================================================
    // State
    tmr_pkg::tmr_state_type r;
    tmr_pkg::tmr_state_type n;

    logic setup_rd;
    logic wr_acc;
    logic mapped;
    logic cnt_wr;
    logic clr_req;
    logic pin_edge;
    logic ev;
    logic psc_full;
    logic ptick;
    logic ext_inc;
    logic inc;
    logic [7:0] low_mask;

    // ======================================================
    // Elaboration check
    if (COUNT_W != 8 || SEL_W != 3 || SYNC_STAGES != 2) begin : g_size_check
        $error("tmr_timer serves only its default sizes");
    end

    // ======================================================
    // Bus decode
    assign setup_rd = psel && !penable && !pwrite;
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    assign mapped = (paddr == `TMR_OFS_COUNT) ||
                    (paddr == `TMR_OFS_OPTION) ||
                    (paddr == `TMR_OFS_INTCTL) ||
                    (paddr == `TMR_OFS_STATUS) ||
                    (paddr == `TMR_OFS_MASK);
    assign cnt_wr = wr_acc && (paddr == `TMR_OFS_COUNT);
    assign clr_req = wr_acc && (
        ((paddr == `TMR_OFS_INTCTL) && pwdata[`TMR_ICTL_FLAG]) ||
        ((paddr == `TMR_OFS_STATUS) && pwdata[`TMR_IRQ_OVF]));

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = r.rdata;

    // ======================================================
    // Event source
    // Second and third sync stages form the edge detector
    assign pin_edge = r.edge_fall ?
        (!r.pin_sync[1] && r.pin_sync[2]) :
        (r.pin_sync[1] && !r.pin_sync[2]);

    // Paused in sleep; mode picks the source
    assign ev = !sleep_active && (r.cnt_mode ? pin_edge :
        (r.qph == tmr_pkg::TMR_Q4));

    // ======================================================
    // Prescaler
    // Select 0 wraps bit 0 (1:2), select 7 wraps bit 7 (1:256)
    assign low_mask = 8'((9'h002 << r.sel) - 9'h001);
    assign psc_full = &(r.psc | ~low_mask);
    assign ptick = r.bypass ? ev : (ev && psc_full);

    // ======================================================
    // Counter mode sampling at Q2 then Q4
    assign ext_inc = (r.qph == tmr_pkg::TMR_Q4) && (r.q2s != r.q4s);
    assign inc = !sleep_active && (r.cnt_mode ? ext_inc : ptick);

    assign irq = r.flag && r.irq_en;

    // ======================================================
    // Next state
    always_comb begin
        n = r;
        n.pin_sync = {r.pin_sync[1:0], ext_count_in};
        if (!sleep_active) begin
            unique case (r.qph)
                tmr_pkg::TMR_Q1: n.qph = tmr_pkg::TMR_Q2;
                tmr_pkg::TMR_Q2: n.qph = tmr_pkg::TMR_Q3;
                tmr_pkg::TMR_Q3: n.qph = tmr_pkg::TMR_Q4;
                tmr_pkg::TMR_Q4: n.qph = tmr_pkg::TMR_Q1;
            endcase
            if (r.qph == tmr_pkg::TMR_Q2) begin
                n.q2s = r.tgl;
            end
            if (r.qph == tmr_pkg::TMR_Q4) begin
                n.q4s = r.q2s;
            end
        end
        if (ev && !r.bypass) begin
            n.psc = r.psc + 8'h01;
        end
        if (ptick) begin
            n.tgl = ~r.tgl;
        end
        // Sleep leaves count untouched
        if (inc) begin
            n.count = r.count + 8'h01;
        end
        if (wr_acc) begin
            unique case (paddr)
                `TMR_OFS_COUNT: begin
                    n.count = pwdata[7:0];
                    n.psc = `TMR_RST_PSC;
                    n.q2s = r.tgl;
                    n.q4s = r.tgl;
                end
                `TMR_OFS_OPTION: begin
                    n.sel = pwdata[`TMR_OPT_SEL_MSB:`TMR_OPT_SEL_LSB];
                    n.bypass = pwdata[`TMR_OPT_BYPASS];
                    n.edge_fall = pwdata[`TMR_OPT_EDGE_FALL];
                    n.cnt_mode = pwdata[`TMR_OPT_CNT_MODE];
                end
                `TMR_OFS_INTCTL: begin
                    n.irq_en = pwdata[`TMR_ICTL_IRQ_EN];
                end
                `TMR_OFS_MASK: begin
                    n.irq_en = pwdata[`TMR_IRQ_OVF];
                end
                default: begin
                end
            endcase
        end
        // Only software clears; a wrap in the same cycle wins
        if (clr_req) begin
            n.flag = 1'b0;
        end
        if (inc && !cnt_wr && (r.count == 8'hff)) begin
            n.flag = 1'b1;
        end
        // Prescaler has no read path
        if (setup_rd) begin
            n.rdata = 32'h0000_0000;
            unique case (paddr)
                `TMR_OFS_COUNT: n.rdata[7:0] = r.count;
                `TMR_OFS_OPTION: begin
                    n.rdata[`TMR_OPT_SEL_MSB:`TMR_OPT_SEL_LSB] = r.sel;
                    n.rdata[`TMR_OPT_BYPASS] = r.bypass;
                    n.rdata[`TMR_OPT_EDGE_FALL] = r.edge_fall;
                    n.rdata[`TMR_OPT_CNT_MODE] = r.cnt_mode;
                end
                `TMR_OFS_INTCTL: begin
                    n.rdata[`TMR_ICTL_FLAG] = r.flag;
                    n.rdata[`TMR_ICTL_IRQ_EN] = r.irq_en;
                end
                `TMR_OFS_STATUS: n.rdata[`TMR_IRQ_OVF] = r.flag;
                `TMR_OFS_MASK: n.rdata[`TMR_IRQ_OVF] = r.irq_en;
                default: begin
                end
            endcase
        end
    end

    // ======================================================
    // Registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            r.count <= `TMR_RST_COUNT;
            r.psc <= `TMR_RST_PSC;
            r.sel <= `TMR_RST_SEL;
            r.bypass <= `TMR_RST_BYPASS;
            r.edge_fall <= `TMR_RST_EDGE_FALL;
            r.cnt_mode <= `TMR_RST_CNT_MODE;
            r.flag <= 1'b0;
            r.irq_en <= 1'b0;
            r.qph <= tmr_pkg::TMR_Q1;
            r.pin_sync <= 3'h0;
            r.tgl <= 1'b0;
            r.q2s <= 1'b0;
            r.q4s <= 1'b0;
            r.rdata <= `TMR_RST_RDATA;
        end else begin
            r <= n;
        end
    end

    // ======================================================
    // Assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_wrap;
        inc && !cnt_wr && (r.count == 8'hff);
    endsequence

    sequence s_ext_seen;
        r.cnt_mode && !sleep_active && !cnt_wr &&
            (r.qph == tmr_pkg::TMR_Q4) && (r.q2s != r.q4s);
    endsequence

    sequence s_ext_quiet;
        r.cnt_mode && !cnt_wr && !((r.qph == tmr_pkg::TMR_Q4) && (r.q2s != r.q4s));
    endsequence

    sequence s_wrap_enabled;
        s_wrap ##0 r.irq_en && !wr_acc;
    endsequence

    a_wrap_sets_flag: assert property (s_wrap |=> r.flag && (r.count == 8'h00))
        else $error("wrap did not set flag");

    a_flag_no_enable: assert property (s_wrap ##0 !r.irq_en && !wr_acc |=> r.flag && !irq)
        else $error("flag not set while interrupt disabled");

    a_flag_sticky: assert property (r.flag && !clr_req |=> r.flag)
        else $error("flag cleared without software");

    a_irq_gated: assert property ($rose(irq) |-> $past(inc) || $past(wr_acc))
        else $error("interrupt rose without cause");

    a_irq_needs_en: assert property (!r.irq_en || !r.flag |-> !irq)
        else $error("interrupt without flag and enable");

    a_sleep_hold: assert property (sleep_active && !cnt_wr |=> r.count == $past(r.count))
        else $error("count moved during sleep");

    a_bypass_each: assert property (
        !r.cnt_mode && r.bypass && !sleep_active && !cnt_wr &&
        (r.qph == tmr_pkg::TMR_Q4) |=> r.count == 8'($past(r.count) + 8'h01))
        else $error("bypass did not count each instruction cycle");

    a_psc_cleared: assert property (cnt_wr |=> (r.psc == 8'h00) && (r.bypass || !inc))
        else $error("count write did not clear prescaler");

    a_div_by_two: assert property (
        !r.cnt_mode && !r.bypass && (r.sel == 3'h0) && ev && !r.psc[0] && !cnt_wr
        |=> r.count == $past(r.count))
        else $error("prescaler 1:2 counted on even event");

    a_ext_sync: assert property (s_ext_seen |=> r.count == 8'($past(r.count) + 8'h01))
        else $error("sampled external edge not counted");

    a_ext_quiet: assert property (s_ext_quiet |=> r.count == $past(r.count))
        else $error("counter mode counted without sampled edge");

    a_irq_on_wrap: assert property (s_wrap_enabled |=> irq)
        else $error("enabled wrap did not raise interrupt");

    a_irq_cleared: assert property (
        clr_req && !(inc && !cnt_wr && (r.count == 8'hff)) |=> !r.flag)
        else $error("software clear left flag set");

    a_psc_step: assert property (
        ev && !r.bypass && !cnt_wr |=> r.psc == 8'($past(r.psc) + 8'h01))
        else $error("prescaler missed an event");

    a_bypass_psc_idle: assert property (
        r.bypass && !cnt_wr |=> r.psc == $past(r.psc))
        else $error("prescaler moved while bypassed");

    a_div_full: assert property (
        !r.cnt_mode && !r.bypass && ev && psc_full && !cnt_wr
        |=> r.count == 8'($past(r.count) + 8'h01))
        else $error("full prescaler did not count");

    a_sleep_frozen: assert property (
        sleep_active && !cnt_wr |=> (r.qph == $past(r.qph)) && (r.psc == $past(r.psc)))
        else $error("phase or prescaler moved during sleep");

    a_count_load: assert property (cnt_wr |=> r.count == $past(pwdata[7:0]))
        else $error("count write did not load");

    a_unmapped_zero: assert property (
        setup_rd && !mapped |=> r.rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

endmodule

`default_nettype wire

//--- inc/tmr_cfg.svh
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// ==========================================================
// Register byte offsets
`define TMR_OFS_COUNT 8'h00
`define TMR_OFS_OPTION 8'h04
`define TMR_OFS_INTCTL 8'h08
`define TMR_OFS_STATUS 8'h0c
`define TMR_OFS_MASK 8'h10

// ==========================================================
// Option register fields
`define TMR_OPT_SEL_LSB 0
`define TMR_OPT_SEL_MSB 2
`define TMR_OPT_BYPASS 3
`define TMR_OPT_EDGE_FALL 4
`define TMR_OPT_CNT_MODE 5

// ==========================================================
// Interrupt control, status and mask fields
`define TMR_ICTL_FLAG 2
`define TMR_ICTL_IRQ_EN 5
`define TMR_IRQ_OVF 0

// ==========================================================
// Reset values
`define TMR_RST_COUNT 8'h00
`define TMR_RST_PSC 8'h00
`define TMR_RST_SEL 3'h0
`define TMR_RST_BYPASS 1'b1
`define TMR_RST_EDGE_FALL 1'b0
`define TMR_RST_CNT_MODE 1'b0
`define TMR_RST_RDATA 32'h0000_0000

// ==========================================================
// Timing: clock phases per instruction cycle
`define TMR_Q_PER_CYCLE 4

`endif

//--- inc/tmr_pkg.sv
package tmr_pkg;

    // ======================================================
    // Instruction clock phase
    typedef enum logic [1:0] {
        TMR_Q1 = 2'b00,
        TMR_Q2 = 2'b01,
        TMR_Q3 = 2'b10,
        TMR_Q4 = 2'b11
    } tmr_qph_type;

    // ======================================================
    // Whole state of the timer
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] psc;
        logic [2:0] sel;
        logic bypass;
        logic edge_fall;
        logic cnt_mode;
        logic flag;
        logic irq_en;
        tmr_qph_type qph;
        logic [2:0] pin_sync;
        logic tgl;
        logic q2s;
        logic q4s;
        logic [31:0] rdata;
    } tmr_state_type;

endpackage

//--- dv/tmr_pulse_src.sv
`timescale 1ns/1ps
`default_nettype none

module tmr_pulse_src #(
    parameter int HALF = 12
) (
    // Clock
    input wire logic clk_sys,
    // Request from bench
    input wire logic go,
    input wire logic [7:0] pulses,
    // Pin side
    output logic pin,
    output logic busy
);
    // ==========================================================
    // Burst of pulses, pin idles low between bursts
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go === 1'b1) begin
                busy <= 1'b1;
                repeat (2 * pulses) begin
                    repeat (HALF) @(posedge clk_sys);
                    pin <= ~pin;
                end
                repeat (HALF) @(posedge clk_sys);
                busy <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

//--- dv/testbench.sv
`include "tmr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic sleep_active, ext_count_in, go, busy;
    logic [7:0] paddr, pulses;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    int miscompares = 0;
    int samples_checked = 0;

    tmr_timer i_tmr_timer (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_active(sleep_active), .ext_count_in(ext_count_in), .irq(irq));
    tmr_pulse_src i_tmr_pulse_src (.clk_sys(clk_sys), .go(go), .pulses(pulses),
        .pin(ext_count_in), .busy(busy));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Reporting
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        miscompares++;
        $display("CHECK FAILED at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            fail($sformatf("got %h want %h..%h", got, lo, hi));
        end
    endtask

    // ==========================================================
    // APB master
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail("no ready");
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdr(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic burst(input logic [7:0] n);
        int k;
        k = 0;
        pulses <= n;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        @(posedge clk_sys);
        while (busy !== 1'b0 && k < 4000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k >= 4000) begin
            fail("pulse source hang");
            conclude();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        fail("timeout");
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        sleep_active = 1'b1;
        go = 1'b0;
        pulses = 8'h00;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rdr(`TMR_OFS_OPTION);
        chk({rd[31:1], err}, 32'h0000_0008, 32'h0000_0008);
        rdr(8'h20);
        chk({rd[31:1], err}, 32'h0000_0001, 32'h0000_0001);
        // Sleep holds count
        repeat (100) @(posedge clk_sys);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0000, 32'h0000_0000);
        wr(`TMR_OFS_COUNT, 32'h0000_0040);
        repeat (100) @(posedge clk_sys);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0040, 32'h0000_0040);
        sleep_active <= 1'b0;
        repeat (40) @(posedge clk_sys);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0049, 32'h0000_004c);
        // Every prescale ratio, four increments each
        for (int s = 0; s < 8; s++) begin
            wr(`TMR_OFS_OPTION, 32'(s));
            rdr(`TMR_OFS_OPTION);
            chk(rd, 32'(s), 32'(s));
            wr(`TMR_OFS_COUNT, 32'h0000_0000);
            repeat ((32 << s) - 2) @(posedge clk_sys);
            rdr(`TMR_OFS_COUNT);
            chk(rd, 32'h0000_0003, 32'h0000_0004);
        end
        // Rewrite just before an increment restarts the prescaler
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        repeat (900) @(posedge clk_sys);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        repeat (900) @(posedge clk_sys);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0000, 32'h0000_0000);
        // Overflow flag and interrupt
        wr(`TMR_OFS_OPTION, 32'h0000_0008);
        wr(`TMR_OFS_COUNT, 32'h0000_00fd);
        repeat (20) @(posedge clk_sys);
        rdr(`TMR_OFS_INTCTL);
        chk(rd, 32'h0000_0004, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0, 32'h0);
        wr(`TMR_OFS_INTCTL, 32'h0000_0020);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1, 32'h1);
        rdr(`TMR_OFS_MASK);
        chk(rd, 32'h0000_0001, 32'h0000_0001);
        repeat (40) @(posedge clk_sys);
        rdr(`TMR_OFS_STATUS);
        chk(rd, 32'h0000_0001, 32'h0000_0001);
        wr(`TMR_OFS_STATUS, 32'h0000_0001);
        rdr(`TMR_OFS_INTCTL);
        chk(rd, 32'h0000_0020, 32'h0000_0020);
        chk({31'h0, irq}, 32'h0, 32'h0);
        // Wrap with interrupt enabled
        wr(`TMR_OFS_COUNT, 32'h0000_00fe);
        repeat (20) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1, 32'h1);
        // Counter mode takes pin edges only
        wr(`TMR_OFS_OPTION, 32'h0000_0028);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        repeat (100) @(posedge clk_sys);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0000, 32'h0000_0000);
        burst(8'h05);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0005, 32'h0000_0005);
        wr(`TMR_OFS_OPTION, 32'h0000_0020);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        burst(8'h06);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0003, 32'h0000_0003);
        // Counter mode on falling pin edges
        wr(`TMR_OFS_OPTION, 32'h0000_0038);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        burst(8'h04);
        rdr(`TMR_OFS_COUNT);
        chk(rd, 32'h0000_0004, 32'h0000_0004);
        conclude();
    end
endmodule

`default_nettype wire
